/* File: common/power_state_pkg.sv */
/*
  Shared constants and types for the power-state sequencer.
  Assumes a single 20 MHz system clock and an active-high async reset.
*/
// Functional notes
// - Rising chip enable restarts into the active state while battery and pad supply are good.
// - After battery power cycle, enable rising edge restarts into active.
// - Enable held low means regulator-off state, all clocks stopped.
// - Loss of the I/O pad supply forces the regulator-off state.
// - Leave regulator-off only on battery reset, enable rise, or pad restore.
// - Pad supply loss, overcurrent or overtemperature change the power state.
// - Host commands may request power state transitions.
// - After an inactivity period the device enters standby by itself.
// - Standby keeps interface state and the wake-up counter clock running.
// - Standby wakes on host, link, detector, counter, temperature, GPIO, protection.
// - Active state runs all clocks and needs the external clock present.
// - Transmitter supply configuration lives in non-volatile memory.
// - Host interface and internal blocks work independent of transmitter.
// - Direct supply disables power control, current sense and overcurrent.
// - Multi-byte values are read least significant byte first.
package power_state_pkg;

  // Power states.
  typedef enum logic [1:0] {
    ST_POWER_OFF = 2'b00,
    ST_REG_OFF = 2'b01,
    ST_STANDBY = 2'b10,
    ST_ACTIVE = 2'b11
  } power_state_t;

  // Host power commands.
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_STANDBY = 2'h1;
  localparam logic [1:0] CMD_ACTIVE = 2'h2;
  localparam logic [1:0] CMD_REG_OFF = 2'h3;

  // Calibration sequence values.
  localparam logic [7:0] CAL_CELL_FIRST = 8'h00;
  localparam logic [7:0] CAL_TRIGGER_VAL = 8'h01;
  localparam logic [7:0] CAL_CELL_LAST = 8'h02;

  // Inactivity time before automatic standby.
  localparam int CLK_HZ = 20000000;
  localparam int IDLE_TIME_US = 100;
  localparam int IDLE_CYCLES = (IDLE_TIME_US * (CLK_HZ / 1000000));

  // Default of the stored supply configuration (regulator in use); supply_reg has no reset and never loads it.
  localparam logic SUPPLY_CFG_RESET = 1'b1;

  // Width of the multi-byte configuration read.
  localparam int CFG_BYTES = 4;

endpackage : power_state_pkg

/* File: hw/pin_sync.sv */
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes the input is asynchronous to i_sys_clk.
*/
`timescale 1ns/1ps
module pin_sync (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_rst, // Async reset, active high.
  input wire logic i_pin, // Raw pin level.
  output logic o_level // Filtered level.
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  logic lvl_next;

  // Update the output only when the second and third stages agree.
  always_comb begin
    lvl_next = lvl_reg;
    if (s2_reg == s3_reg) begin
      lvl_next = s3_reg;
    end
  end

  // Register chain; reset values are constants.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign o_level = lvl_reg;

endmodule : pin_sync

/* File: hw/power_state_sequencer.sv */
/*
  Power-state sequencer: off, regulator-off, standby and active states,
  field enable gating, supply-configuration feature gating and a
  little-endian configuration reader.
  Assumes pins arrive asynchronous; event inputs are on i_sys_clk.
*/
`timescale 1ns/1ps
module power_state_sequencer
  import power_state_pkg::*;
#(
  parameter int IDLE_LIMIT = IDLE_CYCLES,
  parameter int NBYTES = CFG_BYTES
) (
  input wire logic i_sys_clk, // System clock, 20 MHz.
  input wire logic i_rst, // Async reset, active high.
  input wire logic i_chip_enable_input, // Enable pin, async.
  input wire logic i_battery_good, // Main battery present, async.
  input wire logic i_io_pad_supply_good, // Pad supply present, async.
  input wire logic i_ext_clk_ok, // External clock present, async.
  input wire logic i_tx_overcurrent, // Overcurrent event pulse.
  input wire logic i_overtemp, // Overtemperature level.
  input wire logic i_host_cmd_valid, // Host power command strobe.
  input wire logic [1:0] i_host_cmd, // Host power command code.
  input wire logic i_activity, // Any internal activity this cycle.
  input wire logic i_wake_host_if, // Host interface activity.
  input wire logic i_wake_single_wire_link, // Link traffic.
  input wire logic i_wake_low_power_detector, // Detector event.
  input wire logic i_wake_counter_expired, // Wake-up counter expiry.
  input wire logic i_wake_gpio, // General-purpose input event.
  input wire logic i_wake_receive_protection_event, // Receive protection.
  input wire logic i_cal_wr, // Calibration-path write strobe.
  input wire logic i_cal_sel_trigger, // 1: trigger register, 0: cell.
  input wire logic [7:0] i_cal_data, // Calibration write data.
  input wire logic i_supply_cfg_wr, // Store supply configuration.
  input wire logic i_supply_cfg_regulator, // 1: regulator used.
  input wire logic i_supply_cfg_matches, // Config matches wiring.
  input wire logic i_field_req, // Host asks for RF field.
  input wire logic i_cfg_rd_start, // Start configuration read.
  input wire logic [7:0] i_cfg_byte, // Byte at current read address.
  output logic [1:0] o_state, // Current power state.
  output logic o_main_clk_en, // All internal clocks enabled.
  output logic o_wake_clk_en, // Wake-up counter clock enabled.
  output logic o_low_power_mode, // Manager in low-power mode.
  output logic o_hold_interfaces, // Freeze external interfaces.
  output logic o_field_on, // RF field enabled.
  output logic o_calibrated, // Calibration done.
  output logic o_dynamic_power_control_en, // Power control available.
  output logic o_current_meas_en, // Current measurement available.
  output logic o_overcurrent_prot_en, // Overcurrent protection on.
  output logic [1:0] o_cfg_addr, // Configuration byte address.
  output logic [8*CFG_BYTES-1:0] o_cfg_value, // Assembled value.
  output logic o_cfg_done // Read complete pulse.
);

  localparam int CW = $clog2(IDLE_LIMIT + 1);
  localparam logic [CW-1:0] IDLE_MAX = CW'(IDLE_LIMIT);
  localparam logic [1:0] LAST_BYTE = 2'(NBYTES - 1);

  //--------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------
  logic en_lvl;
  logic bat_lvl;
  logic pad_lvl;
  logic xclk_lvl;

  pin_sync u_en (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_pin(i_chip_enable_input), .o_level(en_lvl));
  pin_sync u_bat (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_pin(i_battery_good), .o_level(bat_lvl));
  pin_sync u_pad (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_pin(i_io_pad_supply_good), .o_level(pad_lvl));
  pin_sync u_xclk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_pin(i_ext_clk_ok), .o_level(xclk_lvl));

  //--------------------------------------------------------------
  // Edge detection of filtered levels
  //--------------------------------------------------------------
  logic en_d_reg;
  logic bat_d_reg;
  logic pad_d_reg;
  logic ot_d_reg;
  logic en_rise;
  logic bat_rise;
  logic pad_rise;
  logic pad_fall;
  logic ot_clear;

  // Edges of synchronised levels and of the temperature flag.
  assign en_rise = en_lvl & ~en_d_reg;
  assign bat_rise = bat_lvl & ~bat_d_reg;
  assign pad_rise = pad_lvl & ~pad_d_reg;
  assign pad_fall = ~pad_lvl & pad_d_reg;
  assign ot_clear = ~i_overtemp & ot_d_reg;

  // Previous-level registers.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      en_d_reg <= 1'b0;
      bat_d_reg <= 1'b0;
      pad_d_reg <= 1'b0;
      ot_d_reg <= 1'b0;
    end else begin
      en_d_reg <= en_lvl;
      bat_d_reg <= bat_lvl;
      pad_d_reg <= pad_lvl;
      ot_d_reg <= i_overtemp;
    end
  end

  //--------------------------------------------------------------
  // Power state machine
  //--------------------------------------------------------------
  power_state_t state_reg;
  power_state_t state_next;
  logic [CW-1:0] idle_reg;
  logic [CW-1:0] idle_next;
  logic bat_cycled_reg;
  logic bat_cycled_next;
  logic wake_any;
  logic cmd_ok;

  // Standby wake sources, including temperature back to normal.
  assign wake_any = i_wake_host_if | i_wake_single_wire_link |
    i_wake_low_power_detector | i_wake_counter_expired | i_wake_gpio |
    i_wake_receive_protection_event | ot_clear;
  assign cmd_ok = i_host_cmd_valid & en_lvl;

  // Next state; battery loss first, then enable low and pad loss, take priority over everything else.
  always_comb begin
    state_next = state_reg;
    idle_next = idle_reg;
    bat_cycled_next = bat_cycled_reg;
    if (!bat_lvl) begin
      state_next = ST_POWER_OFF;
      bat_cycled_next = 1'b1;
    end else if (!en_lvl) begin
      state_next = ST_REG_OFF;
    end else if (!pad_lvl) begin
      state_next = ST_REG_OFF;
    end else if (en_rise) begin
      state_next = ST_ACTIVE;
      bat_cycled_next = 1'b0;
    end else begin
      case (state_reg)
        ST_POWER_OFF: begin
          // Battery restored: wait in regulator-off for the enable edge.
          state_next = ST_REG_OFF;
        end
        ST_REG_OFF: begin
          if (pad_rise || (bat_rise && !bat_cycled_reg)) begin
            state_next = ST_ACTIVE;
          end
        end
        ST_STANDBY: begin
          if (wake_any || (cmd_ok && i_host_cmd == CMD_ACTIVE)) begin
            state_next = ST_ACTIVE;
          end else if (cmd_ok && i_host_cmd == CMD_REG_OFF) begin
            state_next = ST_REG_OFF;
          end
        end
        ST_ACTIVE: begin
          if (i_tx_overcurrent || i_overtemp) begin
            state_next = ST_STANDBY;
          end else if (cmd_ok && i_host_cmd == CMD_STANDBY) begin
            state_next = ST_STANDBY;
          end else if (cmd_ok && i_host_cmd == CMD_REG_OFF) begin
            state_next = ST_REG_OFF;
          end else if (idle_reg == IDLE_MAX) begin
            state_next = ST_STANDBY;
          end
        end
        default: begin
          state_next = ST_REG_OFF;
        end
      endcase
    end
    // Inactivity counter runs only while active.
    if (state_next != ST_ACTIVE || state_reg != ST_ACTIVE || i_activity) begin
      idle_next = '0;
    end else if (idle_reg != IDLE_MAX) begin
      idle_next = idle_reg + CW'(1);
    end
  end

  // State registers.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_POWER_OFF;
      idle_reg <= '0;
      bat_cycled_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idle_reg <= idle_next;
      bat_cycled_reg <= bat_cycled_next;
    end
  end

  // Clock and mode controls decoded from the state; the main clock also needs the external clock.
  assign o_state = state_reg;
  assign o_main_clk_en = (state_reg == ST_ACTIVE) & xclk_lvl;
  assign o_wake_clk_en = (state_reg == ST_ACTIVE) ||
    (state_reg == ST_STANDBY);
  assign o_low_power_mode = (state_reg == ST_STANDBY);
  assign o_hold_interfaces = (state_reg == ST_STANDBY);

  //--------------------------------------------------------------
  // Calibration tracking and field gating
  //--------------------------------------------------------------
  logic [1:0] cal_step_reg;
  logic [1:0] cal_step_next;
  logic supply_reg;
  logic supply_next;
  logic field_reg;
  logic field_next;

  // Calibration step tracker follows the three ordered writes.
  always_comb begin
    cal_step_next = cal_step_reg;
    if (i_cal_wr) begin
      if (!i_cal_sel_trigger && i_cal_data == CAL_CELL_FIRST) begin
        cal_step_next = 2'h1;
      end else if (i_cal_sel_trigger && i_cal_data == CAL_TRIGGER_VAL &&
                   cal_step_reg == 2'h1) begin
        cal_step_next = 2'h2;
      end else if (!i_cal_sel_trigger && i_cal_data == CAL_CELL_LAST &&
                   cal_step_reg == 2'h2) begin
        cal_step_next = 2'h3;
      end else if (cal_step_reg != 2'h3) begin
        cal_step_next = 2'h0;
      end
    end
  end

  // Supply configuration store, writable in any powered state.
  always_comb begin
    supply_next = supply_reg;
    if (i_supply_cfg_wr) begin
      supply_next = i_supply_cfg_regulator;
    end
  end

  // Field only in active, after calibration and matching supply config.
  always_comb begin
    field_next = i_field_req & (state_reg == ST_ACTIVE) &
      (cal_step_reg == 2'h3) & i_supply_cfg_matches;
  end

  // Calibration and field registers.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cal_step_reg <= 2'h0;
      field_reg <= 1'b0;
    end else begin
      cal_step_reg <= cal_step_next;
      field_reg <= field_next;
    end
  end

  // Supply configuration models non-volatile storage: no reset term.
  always_ff @(posedge i_sys_clk) begin
    supply_reg <= supply_next;
  end

  assign o_field_on = field_reg;
  assign o_calibrated = (cal_step_reg == 2'h3);
  assign o_dynamic_power_control_en = supply_reg == 1'b1;
  assign o_current_meas_en = supply_reg == 1'b1;
  assign o_overcurrent_prot_en = supply_reg == 1'b1;

  //--------------------------------------------------------------
  // Little-endian configuration reader
  //--------------------------------------------------------------
  logic rd_busy_reg;
  logic rd_busy_next;
  logic [1:0] addr_reg;
  logic [1:0] addr_next;
  logic [8*CFG_BYTES-1:0] val_reg;
  logic [8*CFG_BYTES-1:0] val_next;
  logic done_reg;
  logic done_next;

  // Lower address first; each byte lands in the next higher lane.
  always_comb begin
    rd_busy_next = rd_busy_reg;
    addr_next = addr_reg;
    val_next = val_reg;
    done_next = 1'b0;
    if (!rd_busy_reg) begin
      if (i_cfg_rd_start) begin
        rd_busy_next = 1'b1;
        addr_next = 2'h0;
      end
    end else begin
      val_next[addr_reg*8 +: 8] = i_cfg_byte;
      if (addr_reg == LAST_BYTE) begin
        rd_busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        addr_next = addr_reg + 2'h1;
      end
    end
  end

  // Reader registers.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_busy_reg <= 1'b0;
      addr_reg <= 2'h0;
      val_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      rd_busy_reg <= rd_busy_next;
      addr_reg <= addr_next;
      val_reg <= val_next;
      done_reg <= done_next;
    end
  end

  assign o_cfg_addr = addr_reg;
  assign o_cfg_value = val_reg;
  assign o_cfg_done = done_reg;

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  sequence en_rise_s;
    bat_lvl && pad_lvl && en_rise;
  endsequence

  sequence en_low_s;
    bat_lvl && !en_lvl;
  endsequence

  enable_rise_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    en_rise_s |=> state_reg == ST_ACTIVE)
    else $error("Enable rise did not reach active.");

  enable_low_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    en_low_s |=> state_reg == ST_REG_OFF && !o_main_clk_en)
    else $error("Enable low did not give regulator-off.");

  pad_loss_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    bat_lvl && !pad_lvl |=> state_reg == ST_REG_OFF)
    else $error("Pad loss did not give regulator-off.");

  regoff_exit_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_reg == ST_REG_OFF && state_next == ST_ACTIVE |->
    en_rise || pad_rise || bat_rise)
    else $error("Regulator-off left without a wake event.");

  fault_exit_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_reg == ST_ACTIVE && bat_lvl && en_lvl && pad_lvl && !en_rise &&
    i_tx_overcurrent |=> state_reg == ST_STANDBY)
    else $error("Overcurrent did not leave active.");

  idle_standby_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_reg == ST_ACTIVE && idle_reg == IDLE_MAX && bat_lvl && en_lvl &&
    pad_lvl && !en_rise |=> state_reg == ST_STANDBY)
    else $error("Idle limit did not enter standby.");

  standby_wake_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_reg == ST_STANDBY && wake_any && bat_lvl && en_lvl && pad_lvl
    |=> state_reg == ST_ACTIVE)
    else $error("Wake source ignored in standby.");

  standby_clk_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_reg == ST_STANDBY |-> o_wake_clk_en && o_hold_interfaces)
    else $error("Standby lost wake clock.");

  field_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_field_on) |-> $past(cal_step_reg) == 2'h3)
    else $error("Field on before calibration.");

  cfg_order_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !rd_busy_reg && i_cfg_rd_start |=> o_cfg_addr == 2'h0 ##1
    o_cfg_addr == 2'h1)
    else $error("Configuration read not lowest byte first.");

endmodule : power_state_sequencer

/* File: tb/host_model.sv */
/*
  Host controller model: drives the enable pin, power commands,
  calibration writes, supply configuration and the field request.
  Assumes all requests start just after a rising edge of i_sys_clk.
*/
`timescale 1ns/1ps
module host_model
  import power_state_pkg::*;
(
  input wire logic i_sys_clk, // System clock.
  output logic o_en, // Enable pin level.
  output logic o_cmd_valid, // Power command strobe.
  output logic [1:0] o_cmd, // Power command code.
  output logic o_cal_wr, // Calibration write strobe.
  output logic o_cal_trig, // 1: trigger register, 0: cell.
  output logic [7:0] o_cal_data, // Calibration write data.
  output logic o_sup_wr, // Store supply configuration.
  output logic o_sup_reg, // 1: regulator feeds transmitter.
  output logic o_sup_match, // Stored config matches wiring.
  output logic o_field_req // Field request level.
);
  // -------------------------------------------------------------------
  // Request tasks
  // -------------------------------------------------------------------
  // All outputs start idle with the enable pin low.
  initial begin
    {o_en, o_cmd_valid, o_cal_wr, o_cal_trig, o_sup_wr} = 5'h00;
    {o_sup_reg, o_sup_match, o_field_req} = 3'h0;
    o_cmd = CMD_NONE;
    o_cal_data = 8'h00;
  end

  // Every change lands one nanosecond after a rising edge.
  task automatic step();
    @(posedge i_sys_clk);
    #1;
  endtask : step

  // Holding the pin low parks the device in regulator-off.
  task automatic set_enable(input logic lvl);
    step();
    o_en = lvl;
  endtask : set_enable

  // One-cycle command strobe.
  task automatic command(input logic [1:0] c);
    step();
    o_cmd_valid = 1'b1;
    o_cmd = c;
    step();
    o_cmd_valid = 1'b0;
    o_cmd = CMD_NONE;
  endtask : command

  // One write on the calibration path.
  task automatic cal_write(input logic trig, input logic [7:0] d);
    step();
    o_cal_wr = 1'b1;
    o_cal_trig = trig;
    o_cal_data = d;
    step();
    o_cal_wr = 1'b0;
  endtask : cal_write

  // Full calibration with the antenna unloaded, before any field.
  task automatic calibrate();
    cal_write(1'b0, CAL_CELL_FIRST);
    cal_write(1'b1, CAL_TRIGGER_VAL);
    cal_write(1'b0, CAL_CELL_LAST);
  endtask : calibrate

  // Store the transmitter supply choice.
  task automatic store_supply(input logic reg_used);
    step();
    o_sup_wr = 1'b1;
    o_sup_reg = reg_used;
    step();
    o_sup_wr = 1'b0;
  endtask : store_supply

  // Field request together with the wiring match flag.
  task automatic set_field(input logic req, input logic match);
    step();
    o_field_req = req;
    o_sup_match = match;
  endtask : set_field
endmodule : host_model

/* File: tb/tb.sv */
/*
  Self-checking bench for the power-state sequencer.
  Assumes the package, design and host model are compiled first.
*/
`timescale 1ns/1ps
module tb;
  import power_state_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bat = 1'b1, pad = 1'b1, xclk = 1'b1, oc = 1'b0, otemp = 1'b0;
  logic act = 1'b1, rd = 1'b0;
  logic [5:0] wk = 6'h00;
  logic [7:0] mem [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] cbyte;
  logic en, cv, cw, ct, sw, sr, sm, fr;
  logic [1:0] cmd, st, addr;
  logic [7:0] cd;
  logic mclk, wclk, lpm, hold, fon, cal, pwr_ctl, cm, ocp, done;
  logic [31:0] val;
  int seed = 70957;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Configuration memory seen at the read address.
  assign cbyte = mem[addr];

  // Clock at 20 MHz.
  always #25 clk = ~clk;

  host_model i_host (.i_sys_clk(clk), .o_en(en), .o_cmd_valid(cv),
    .o_cmd(cmd), .o_cal_wr(cw), .o_cal_trig(ct), .o_cal_data(cd),
    .o_sup_wr(sw), .o_sup_reg(sr), .o_sup_match(sm), .o_field_req(fr));

  power_state_sequencer #(.IDLE_LIMIT(8), .NBYTES(4)) i_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_chip_enable_input(en),
    .i_battery_good(bat), .i_io_pad_supply_good(pad), .i_ext_clk_ok(xclk),
    .i_tx_overcurrent(oc), .i_overtemp(otemp), .i_host_cmd_valid(cv),
    .i_host_cmd(cmd), .i_activity(act), .i_wake_host_if(wk[0]),
    .i_wake_single_wire_link(wk[1]), .i_wake_low_power_detector(wk[2]),
    .i_wake_counter_expired(wk[3]), .i_wake_gpio(wk[4]),
    .i_wake_receive_protection_event(wk[5]), .i_cal_wr(cw),
    .i_cal_sel_trigger(ct), .i_cal_data(cd), .i_supply_cfg_wr(sw),
    .i_supply_cfg_regulator(sr), .i_supply_cfg_matches(sm),
    .i_field_req(fr), .i_cfg_rd_start(rd), .i_cfg_byte(cbyte),
    .o_state(st), .o_main_clk_en(mclk), .o_wake_clk_en(wclk),
    .o_low_power_mode(lpm), .o_hold_interfaces(hold), .o_field_on(fon),
    .o_calibrated(cal), .o_dynamic_power_control_en(pwr_ctl),
    .o_current_meas_en(cm), .o_overcurrent_prot_en(ocp),
    .o_cfg_addr(addr), .o_cfg_value(val), .o_cfg_done(done));

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Model of the state and its decoded clock and hold outputs.
  task automatic expect_state(input string nm, input int s);
    cyc(8);
    check(nm, st, s);
    check({nm, "_mclk"}, mclk, s == 3 && xclk === 1'b1);
    if (s == 2) begin
      check({nm, "_sby"}, {wclk, lpm, hold}, 3'h7);
    end
    if (s < 2) begin
      check({nm, "_wclk"}, wclk, 1'b0);
    end
  endtask : expect_state

  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // Cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    cyc(4);
    rst = 1'b0;
    expect_state("en_low", 1);
    i_host.command(CMD_ACTIVE);
    wk = 6'h3f;
    cyc(1);
    wk = 6'h00;
    expect_state("low_override", 1);
    $display("test enable_low done");
    i_host.set_enable(1'b1);
    expect_state("en_rise", 3);
    xclk = 1'b0;
    expect_state("no_xclk", 3);
    xclk = 1'b1;
    for (int k = 0; k < 6; k++) begin
      i_host.command(CMD_STANDBY);
      expect_state("cmd_sby", 2);
      wk = 6'h01 << k;
      cyc(1);
      wk = 6'h00;
      expect_state("wake", 3);
    end
    otemp = 1'b1;
    expect_state("otemp", 2);
    otemp = 1'b0;
    expect_state("temp_ok", 3);
    oc = 1'b1;
    cyc(1);
    oc = 1'b0;
    expect_state("overcur", 2);
    i_host.command(CMD_ACTIVE);
    expect_state("cmd_act", 3);
    $display("test wake done");
    act = 1'b0;
    cyc(4);
    check("idle_early", st, 2'h3);
    cyc(8);
    check("idle", st, 2'h2);
    act = 1'b1;
    i_host.command(CMD_ACTIVE);
    expect_state("idle_back", 3);
    pad = 1'b0;
    expect_state("pad_loss", 1);
    pad = 1'b1;
    expect_state("pad_back", 3);
    i_host.command(CMD_REG_OFF);
    expect_state("cmd_off", 1);
    i_host.set_enable(1'b0);
    expect_state("off_low", 1);
    i_host.set_enable(1'b1);
    expect_state("off_rise", 3);
    bat = 1'b0;
    expect_state("bat_low", 0);
    bat = 1'b1;
    expect_state("bat_back", 1);
    i_host.set_enable(1'b0);
    expect_state("bat_en_low", 1);
    i_host.set_enable(1'b1);
    expect_state("bat_en_rise", 3);
    $display("test power_events done");
    i_host.store_supply(1'b1);
    i_host.set_field(1'b1, 1'b1);
    cyc(3);
    check("field_uncal", fon, 1'b0);
    i_host.cal_write(1'b1, CAL_TRIGGER_VAL);
    i_host.cal_write(1'b0, CAL_CELL_LAST);
    cyc(2);
    check("cal_bad_order", cal, 1'b0);
    i_host.calibrate();
    cyc(2);
    check("cal_done", cal, 1'b1);
    check("field_on", fon, 1'b1);
    i_host.set_field(1'b1, 1'b0);
    cyc(3);
    check("field_nomatch", fon, 1'b0);
    i_host.set_field(1'b1, 1'b1);
    i_host.command(CMD_STANDBY);
    expect_state("field_sby", 2);
    check("field_sby_off", fon, 1'b0);
    i_host.command(CMD_ACTIVE);
    expect_state("field_act", 3);
    $display("test field done");
    for (int r = 0; r < 2; r++) begin
      i_host.store_supply(r[0]);
      cyc(2);
      check("supply_feat", {pwr_ctl, cm, ocp}, {3{r[0]}});
    end
    for (int n = 0; n < 3; n++) begin
      for (int i = 0; i < 4; i++) begin
        mem[i] = 8'($random(seed));
      end
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      for (int w = 0; w < 20 && done !== 1'b1; w++) begin
        cyc(1);
      end
      check("rd_done", done, 1'b1);
      check("rd_value", val, {mem[3], mem[2], mem[1], mem[0]});
      check("rd_addr", addr, 2'h3);
      cyc(1);
    end
    $display("test config_read done");
    i_host.store_supply(1'b0);
    cyc(2);
    rst = 1'b1;
    cyc(4);
    rst = 1'b0;
    cyc(1);
    check("rst_state", st, 2'h0);
    check("supply_kept", {pwr_ctl, cm, ocp}, 3'h0);
    check("cal_cleared", cal, 1'b0);
    $display("test retention done");
    results();
  end
endmodule : tb
